// ===== hw/sld_defs.vh
`ifndef SLD_DEFS_VH
`define SLD_DEFS_VH

// ****************************************
// Geometry
// ****************************************
`define SLD_NUM_SEG 40
`define SLD_NUM_COM 4
`define SLD_LAST_IDX 6'h27
`define SLD_PTR_RST 6'h00

// ****************************************
// Pointer field positions
// ****************************************
`define SLD_PTR_LO_MSB 3
`define SLD_PTR_LO_LSB 0
`define SLD_PTR_HI_MSB 5
`define SLD_PTR_HI_LSB 4

// ****************************************
// Divider select codes and reset value
// ****************************************
`define SLD_DIV_64 2'h0
`define SLD_DIV_128 2'h1
`define SLD_DIV_256 2'h2
`define SLD_DIV_512 2'h3
`define SLD_DIV_RST 2'h0

// ****************************************
// Half periods of the alternating clock less one, in source ticks
// ****************************************
`define SLD_HALF_64 8'h1f
`define SLD_HALF_128 8'h3f
`define SLD_HALF_256 8'h7f
`define SLD_HALF_512 8'hff

// ****************************************
// Drive level codes, 1/3 bias steps
// ****************************************
`define SLD_LVL_V0 2'h0
`define SLD_LVL_V1 2'h1
`define SLD_LVL_V2 2'h2
`define SLD_LVL_V3 2'h3

`endif

// ===== hw/sld_segment_lcd_driver.v
`timescale 1ns/10ps
`include "sld_defs.vh"

module sld_segment_lcd_driver (
    input wire core_clk,
    input wire rst,
    input wire sourceClock32k,
    input wire [3:0] instrData,
    input wire pointerLowWr,
    input wire pointerHighWr,
    input wire nibbleWr,
    input wire nibbleRd,
    input wire displayOnInstr,
    input wire displayOffInstr,
    input wire divSelWr,
    output wire [3:0] rdData,
    output wire rdValid,
    output wire [79:0] segmentLevel,
    output wire [7:0] commonLevel,
    output wire displayActive
);

    // ****************************************
    // Display states, one-hot
    // ****************************************
    localparam [1:0] ST_OFF = 2'h1;
    localparam [1:0] ST_ON = 2'h2;

    // ****************************************
    // Level mapping
    // ****************************************
    // Common level; a segment uses the bitwise inverse
    function [1:0] comLevel;
        input sel;
        input ph;
        begin
            if (sel) begin
                comLevel = ph ? `SLD_LVL_V0 : `SLD_LVL_V3;
            end else begin
                comLevel = ph ? `SLD_LVL_V2 : `SLD_LVL_V1;
            end
        end
    endfunction

    // ****************************************
    // Divider lookup
    // ****************************************
    function [7:0] halfTicks;
        input [1:0] sel;
        begin
            case (sel)
                `SLD_DIV_64: halfTicks = `SLD_HALF_64;
                `SLD_DIV_128: halfTicks = `SLD_HALF_128;
                `SLD_DIV_256: halfTicks = `SLD_HALF_256;
                default: halfTicks = `SLD_HALF_512;
            endcase
        end
    endfunction

    // ****************************************
    // State
    // ****************************************
    // nibble storage
    reg [3:0] dispMem [0:`SLD_NUM_SEG-1];
    reg [5:0] dispPtr_reg;
    reg [1:0] divSel_reg;
    reg [1:0] state_reg;
    reg [3:0] rdData_reg;
    reg rdValid_reg;
    reg srcPrev_reg;
    reg [7:0] tickCnt_reg;
    reg phase_reg;
    reg [1:0] comIdx_reg;
    reg [79:0] segLevel_reg;
    reg [7:0] comLevel_reg;
    reg [79:0] segLevel_next;
    reg [7:0] comLevel_next;
    reg [1:0] state_next;
    reg [5:0] dispPtr_next;
    reg [1:0] divSel_next;
    reg [7:0] tickCnt_next;
    reg phase_next;
    reg [1:0] comIdx_next;
    wire ptrOk;
    wire srcEdge;
    wire isOn;
    wire halfEnd;
    integer i;
    integer k;

    // ****************************************
    // Source edge and status decode
    // ****************************************
    assign ptrOk = (dispPtr_reg <= `SLD_LAST_IDX);
    assign srcEdge = sourceClock32k & ~srcPrev_reg;
    assign isOn = (state_reg == ST_ON);
    assign halfEnd = (tickCnt_reg >= halfTicks(divSel_reg));

    // ****************************************
    // Pointer and divider field
    // ****************************************
    always @* begin
        dispPtr_next = dispPtr_reg;
        divSel_next = divSel_reg;
        if (pointerLowWr) begin
            dispPtr_next[`SLD_PTR_LO_MSB:`SLD_PTR_LO_LSB] = instrData;
        end
        if (pointerHighWr) begin
            dispPtr_next[`SLD_PTR_HI_MSB:`SLD_PTR_HI_LSB] = instrData[1:0];
        end
        if (divSelWr) begin
            divSel_next = instrData[1:0];
        end
    end

    // ****************************************
    // Pointer and divider registers
    // ****************************************
    always @(posedge core_clk) begin
        if (rst) begin
            dispPtr_reg <= `SLD_PTR_RST;
            divSel_reg <= `SLD_DIV_RST;
        end else begin
            dispPtr_reg <= dispPtr_next;
            divSel_reg <= divSel_next;
        end
    end

    // ****************************************
    // Display memory access
    // ****************************************
    always @(posedge core_clk) begin
        if (rst) begin
            for (i = 0; i < `SLD_NUM_SEG; i = i + 1) begin
                dispMem[i] <= 4'h0;
            end
            rdData_reg <= 4'h0;
            rdValid_reg <= 1'b0;
        end else begin
            if (nibbleWr && ptrOk) begin
                dispMem[dispPtr_reg] <= instrData;
            end
            rdValid_reg <= nibbleRd;
            if (nibbleRd) begin
                rdData_reg <= ptrOk ? dispMem[dispPtr_reg] : 4'h0;
            end
        end
    end

    // ****************************************
    // Display on/off
    // ****************************************
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_OFF: begin
                if (displayOnInstr && !displayOffInstr) begin
                    state_next = ST_ON;
                end
            end
            ST_ON: begin
                if (displayOffInstr) begin
                    state_next = ST_OFF;
                end
            end
            default: state_next = ST_OFF;
        endcase
    end

    // ****************************************
    // Display state register
    // ****************************************
    always @(posedge core_clk) begin
        if (rst) begin
            state_reg <= ST_OFF;
        end else begin
            state_reg <= state_next;
        end
    end

    // ****************************************
    // Alternating clock and common scan
    // ****************************************
    always @* begin
        tickCnt_next = tickCnt_reg;
        phase_next = phase_reg;
        comIdx_next = comIdx_reg;
        if (!isOn) begin
            tickCnt_next = 8'h00;
            phase_next = 1'b0;
            comIdx_next = 2'h0;
        end else if (srcEdge) begin
            if (halfEnd) begin
                tickCnt_next = 8'h00;
                phase_next = ~phase_reg;
                if (phase_reg) begin
                    comIdx_next = comIdx_reg + 2'h1;
                end
            end else begin
                tickCnt_next = tickCnt_reg + 8'h01;
            end
        end
    end

    // ****************************************
    // Scan registers
    // ****************************************
    always @(posedge core_clk) begin
        if (rst) begin
            srcPrev_reg <= 1'b0;
            tickCnt_reg <= 8'h00;
            phase_reg <= 1'b0;
            comIdx_reg <= 2'h0;
        end else begin
            srcPrev_reg <= sourceClock32k;
            tickCnt_reg <= tickCnt_next;
            phase_reg <= phase_next;
            comIdx_reg <= comIdx_next;
        end
    end

    // ****************************************
    // Waveform levels
    // ****************************************
    always @* begin
        segLevel_next = 80'h0000_0000_0000_0000_0000;
        comLevel_next = 8'h00;
        if (isOn) begin
            // one common selected at a time
            for (k = 0; k < `SLD_NUM_COM; k = k + 1) begin
                comLevel_next[2*k +: 2] = comLevel(comIdx_reg == k[1:0], phase_reg);
            end
            for (k = 0; k < `SLD_NUM_SEG; k = k + 1) begin
                segLevel_next[2*k +: 2] = ~comLevel(dispMem[k][comIdx_reg], phase_reg);
            end
        end
    end

    // ****************************************
    // Level registers
    // ****************************************
    always @(posedge core_clk) begin
        if (rst) begin
            segLevel_reg <= 80'h0000_0000_0000_0000_0000;
            comLevel_reg <= 8'h00;
        end else begin
            segLevel_reg <= segLevel_next;
            comLevel_reg <= comLevel_next;
        end
    end

    // ****************************************
    // Display active flag
    // ****************************************
    reg active_reg;
    always @(posedge core_clk) begin
        if (rst) begin
            active_reg <= 1'b0;
        end else begin
            active_reg <= isOn;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign rdData = rdData_reg;
    assign rdValid = rdValid_reg;
    assign segmentLevel = segLevel_reg;
    assign commonLevel = comLevel_reg;
    assign displayActive = active_reg;

endmodule // sld_segment_lcd_driver

// ===== tb/sld_lcd_assertions.sv
`timescale 1ns/10ps
module sld_lcd_assertions (
    input wire core_clk,
    input wire rst,
    input wire sourceClock32k,
    input wire [3:0] instrData,
    input wire pointerLowWr,
    input wire pointerHighWr,
    input wire nibbleWr,
    input wire nibbleRd,
    input wire displayOnInstr,
    input wire displayOffInstr,
    input wire divSelWr,
    input wire [3:0] rdData,
    input wire rdValid,
    input wire [79:0] segmentLevel,
    input wire [7:0] commonLevel,
    input wire displayActive
);
    // ****
    // Port checks
    // ****
    localparam logic [79:0] LSB_MASK = 80'h5555_5555_5555_5555_5555;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    a_rd_answer: assert property (nibbleRd |=> rdValid)
        else $error("read without answer");
    a_rd_quiet: assert property (!nibbleRd |=> !rdValid)
        else $error("spurious read answer");
    a_off_dark: assert property
        (displayOffInstr |-> ##2 (commonLevel == 8'h00 && segmentLevel == 80'h0))
        else $error("levels driven after off");
    a_on_start: assert property
        (displayOnInstr && !displayOffInstr |-> ##[1:2] displayActive)
        else $error("display did not start");
    a_off_wins: assert property (displayOnInstr && displayOffInstr |-> ##2 !displayActive)
        else $error("on beat off");
    a_on_holds: assert property
        (displayActive && !displayOffInstr && !$past(displayOffInstr) |=> displayActive)
        else $error("display dropped by itself");
    a_com_duty: assert property
        (commonLevel inside {8'h00, 8'h57, 8'h5d, 8'h75, 8'hd5, 8'ha8, 8'ha2, 8'h8a, 8'h2a})
        else $error("bad common pattern");
    a_seg_phase: assert property
        (commonLevel != 8'h00 |->
            (segmentLevel & LSB_MASK) == (commonLevel[0] ? 80'h0 : LSB_MASK))
        else $error("segment phase mismatch");
    c_read: cover property (nibbleRd ##1 rdValid);
    c_on: cover property (displayOnInstr ##2 displayActive);
    c_ph1: cover property (commonLevel == 8'ha8);
endmodule // sld_lcd_assertions

bind sld_segment_lcd_driver sld_lcd_assertions u_sld_lcd_assertions (
    .core_clk, .rst, .sourceClock32k, .instrData, .pointerLowWr, .pointerHighWr,
    .nibbleWr, .nibbleRd, .displayOnInstr, .displayOffInstr, .divSelWr,
    .rdData, .rdValid, .segmentLevel, .commonLevel, .displayActive
);

// ===== tb/sld_panel_model.sv
`timescale 1ns/10ps
module sld_panel_model (
    input wire [79:0] segmentLevel,
    input wire [7:0] commonLevel,
    output logic [159:0] litDot
);
    // ****
    // Dot voltage
    // ****
    // three-step dots
    always_comb begin
        for (int k = 0; k < 40; k++) begin
            for (int n = 0; n < 4; n++) begin
                litDot[k*4+n] = {commonLevel[n*2+:2], segmentLevel[k*2+:2]} inside {4'hc, 4'h3};
            end
        end
    end
endmodule // sld_panel_model

// ===== tb/testbench.sv
`timescale 1ns/10ps
module testbench;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic sourceClock32k = 1'b0;
    logic [3:0] instrData = 4'h0;
    logic [6:0] strobes = 7'h00;
    logic [3:0] rdData;
    logic rdValid;
    logic [79:0] segmentLevel;
    logic [7:0] commonLevel;
    logic displayActive;
    logic [159:0] litDot;
    logic [4:0] cap;
    int err_total = 0;
    int n_tests = 0;
    int n;
    logic [13:0] rows [5] = '{14'h00aa, 14'h2755, 14'h28f0, 14'h3f30, 14'h15cc};
    sld_segment_lcd_driver u_sld_segment_lcd_driver (
        .core_clk, .rst, .sourceClock32k, .instrData,
        .pointerLowWr(strobes[6]), .pointerHighWr(strobes[5]), .nibbleWr(strobes[4]),
        .nibbleRd(strobes[3]), .displayOnInstr(strobes[2]), .displayOffInstr(strobes[1]),
        .divSelWr(strobes[0]), .rdData, .rdValid, .segmentLevel, .commonLevel, .displayActive
    );
    sld_panel_model u_sld_panel_model (.segmentLevel, .commonLevel, .litDot);
    // ****
    // Clocks and tasks
    // ****
    initial forever #4 core_clk = ~core_clk;
    initial forever begin
        repeat (4) @(posedge core_clk);
        sourceClock32k <= ~sourceClock32k;
    end
    initial begin
        #300000;
        err_total++;
        test_done();
    end
    task automatic op(input logic [6:0] s, input logic [3:0] d);
        strobes <= s;
        instrData <= d;
        @(posedge core_clk);
        strobes <= 7'h00;
        #1;
        cap = {rdValid, rdData};
        @(posedge core_clk);
    endtask
    task automatic chk(input string nm, input logic [95:0] e, input logic [95:0] g);
        n_tests++;
        if (g !== e) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic waitChg();
        logic [7:0] prev;
        prev = commonLevel;
        n = 0;
        while (commonLevel === prev && n < 5000) begin
            @(posedge core_clk);
            #1;
            n++;
        end
    endtask
    task automatic test_done();
        $display("checks %0d errors %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // ****
    // Sequence
    // ****
    initial begin
        repeat (12) @(posedge core_clk);
        #1;
        chk("resetOutputs", 96'h0, {commonLevel, displayActive, rdValid});
        @(posedge core_clk);
        rst <= 1'b0;
        for (int i = 0; i < 5; i++) begin
            op(7'h40, rows[i][11:8]);
            op(7'h20, {2'b00, rows[i][13:12]});
            op(7'h10, rows[i][7:4]);
            op(7'h08, 4'h0);
            chk("rdNibble", {1'b1, rows[i][3:0]}, cap);
        end
        op(7'h04, 4'h0);
        repeat (2) @(posedge core_clk);
        #1;
        chk("comPhase0", 8'h57, commonLevel);
        chk("litDots", 4'h9, {litDot[156], litDot[0], litDot[84], displayActive});
        for (int i = 0; i < 4; i++) begin
            @(posedge core_clk);
            if (i > 0) op(7'h01, i[3:0]);
            #1;
            waitChg();
            if (i == 0) chk("comPhase1", 8'ha8, commonLevel);
            waitChg();
            waitChg();
            chk("halfPeriod", 256 << i, n);
        end
        @(posedge core_clk);
        op(7'h06, 4'h0);
        repeat (2) @(posedge core_clk);
        #1;
        chk("offLevels", 96'h0, {commonLevel, displayActive, segmentLevel});
        @(posedge core_clk);
        rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        op(7'h08, 4'h0);
        chk("rdAfterReset", 5'h10, cap);
        test_done();
    end
endmodule // testbench
